// file: mac_phy_mgmt_and_filter_access.sv
// host registers for phy management, filter table access, entry enables and the missed-packet counter
//
// Overview of operation
// - 16-bit management data, soft reset clears
// - busy bit 11 set on start, self-clears
// - bit 10 one writes, zero reads
// - bits 9:5 hold target phy address
// - bits 4:0 hold phy register number
// - control only drives management, never packets
// - pointer holds word address in 11:2
// - soft reset clears the pointer
// - normal mode: table writable, others ignored
// - test mode reaches all dma ram
// - window access is whole word, enables ignored
// - window read repeatable, write updates word
// - table words presented big-endian
// - one enable bit per entry 0..20
// - hard reset clears enables, soft keeps
// - counts discarded packets, hard reset clears
// - read returns count and clears it
// - 0x7fff to 0x8000 sets wrap flag, irq
// - counter writable to preset near wrap
// - offsets 0x74..0x78 reserved, no function
`include "mac_mgmt_consts.svh"
`default_nettype none
module mac_phy_mgmt_and_filter_access #(
  parameter int NORMAL_WORDS = 64,     // filter table words reachable in normal mode
  parameter int RAM_WORDS    = 1024,   // all dma ram words reachable in test mode
  parameter int ENTRIES      = 21,     // filter entries with an enable bit
  parameter int MDC_HALF     = `MDC_HALF_CYCLES
) (
  // clock, reset and enable
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_soft_rst,
  // host register port
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [31:0] i_reg_wdata,
  input  wire logic [3:0]  i_reg_be,
  output logic [31:0]      o_reg_rdata,
  output logic             o_reg_rvalid,
  // receive path events and mac control bits
  input  wire logic        i_rx_missed,
  input  wire logic        i_ram_test_select,
  input  wire logic        i_miss_wrap_irq_enable,
  input  wire logic        i_miss_wrap_flag_clr,
  output logic             o_miss_counter_wrap_flag,
  output logic             o_miss_wrap_irq,
  // address filter datapath
  output logic [ENTRIES-1:0] o_filter_entry_enable,
  input  wire logic [9:0]  i_lookup_addr,
  output logic [31:0]      o_lookup_data,
  // management pins
  output logic             o_mdc,
  input  wire logic        i_mdio_in,
  output logic             o_mdio_out,
  output logic             o_mdio_oe
);
  // refuse sizes the pointer or enable register cannot carry
  initial begin
    if (RAM_WORDS < 1 || RAM_WORDS > 1024) $error("ram words must be 1..1024");
    if (NORMAL_WORDS < 1 || NORMAL_WORDS > RAM_WORDS) $error("normal words must be 1..ram words");
    if (ENTRIES < 1 || ENTRIES > 21) $error("entries must be 1..21");
  end

  // state

  logic [15:0]        mgmt_data_q;    // management data field
  logic [15:0]        mgmt_data_d;
  logic [10:0]        mgmt_ctl_q;     // write/phy/reg fields, busy kept apart
  logic [10:0]        mgmt_ctl_d;
  logic               busy_q;         // management transaction in flight
  logic               busy_d;
  logic [9:0]         ptr_q;          // filter table word pointer
  logic [9:0]         ptr_d;
  logic [ENTRIES-1:0] enable_q;       // per-entry filter enable
  logic [ENTRIES-1:0] enable_d;
  logic [31:0]        miss_q;         // missed-packet counter
  logic [31:0]        miss_d;
  logic               wrap_q;         // counter wrap flag
  logic               wrap_d;
  logic [31:0]        rdata_q;        // registered read data
  logic               rvalid_q;       // read answer strobe

  // address decode

  wire hit_data   = (i_reg_addr == `OFS_PHY_MGMT_DATA);
  wire hit_ctl    = (i_reg_addr == `OFS_PHY_MGMT_CTRL);
  wire hit_ptr    = (i_reg_addr == `OFS_FILTER_POINTER);
  wire hit_win    = (i_reg_addr == `OFS_FILTER_WINDOW);
  wire hit_en     = (i_reg_addr == `OFS_FILTER_ENABLE);
  wire hit_miss   = (i_reg_addr == `OFS_MISS_COUNT);

  // byte lane mask for ordinary registers
  wire [31:0] wmask = {{8{i_reg_be[3]}}, {8{i_reg_be[2]}}, {8{i_reg_be[1]}}, {8{i_reg_be[0]}}};

  // write strobes
  wire wr_data    = i_reg_wr && hit_data;
  wire wr_ctl     = i_reg_wr && hit_ctl;
  wire wr_ptr     = i_reg_wr && hit_ptr;
  wire wr_win     = i_reg_wr && hit_win;   // whole word, enables ignored
  wire wr_en      = i_reg_wr && hit_en;
  wire wr_miss    = i_reg_wr && hit_miss;
  wire rd_miss    = i_reg_rd && hit_miss;

  // merged write values for lane-aware registers
  wire [31:0] data_merge = ({16'h0000, mgmt_data_q} & ~wmask) | (i_reg_wdata & wmask);
  wire [11:0] ctl_merge  = ({busy_q, mgmt_ctl_q} & ~wmask[11:0]) | (i_reg_wdata[11:0] & wmask[11:0]);
  wire [31:0] ptr_merge  = ({20'h0, ptr_q, 2'b00} & ~wmask) | (i_reg_wdata & wmask);
  wire [31:0] en_merge   = (32'(enable_q) & ~wmask) | (i_reg_wdata & wmask);
  wire [31:0] miss_merge = (miss_q & ~wmask) | (i_reg_wdata & wmask);

  // management transaction start and completion

  // a control write with busy set launches a frame; writes during busy are dropped
  // so the frame in flight cannot be corrupted when software skips the busy check
  wire        mgmt_start = wr_ctl && !busy_q && ctl_merge[`CTL_BUSY_BIT];
  wire        mgmt_wr    = ctl_merge[`CTL_WRITE_BIT];
  wire [4:0]  mgmt_phy   = ctl_merge[`CTL_PHY_HI:`CTL_PHY_LO];
  wire [4:0]  mgmt_reg   = ctl_merge[`CTL_REG_HI:`CTL_REG_LO];
  wire        mgmt_done;                                                    // one-cycle completion
  wire [15:0] mgmt_rdata;                                                   // word returned by phy

  // control fields reach only the frame engine, nothing on the packet path
  mdio_frame_engine #(
    .MDC_HALF (MDC_HALF)
  ) u_mdio (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_clk_en   (i_clk_en),
    .i_abort    (i_soft_rst),
    .i_start    (mgmt_start),
    .i_write    (mgmt_wr),
    .i_phy      (mgmt_phy),
    .i_reg      (mgmt_reg),
    .i_wdata    (mgmt_data_q),   // data field goes out on a write frame
    .o_done     (mgmt_done),
    .o_rdata    (mgmt_rdata),
    .o_mdc      (o_mdc),
    .i_mdio_in  (i_mdio_in),
    .o_mdio_out (o_mdio_out),
    .o_mdio_oe  (o_mdio_oe)
  );

  // filter table window

  // normal mode limits writes to the filter area; test mode opens all ram
  wire        win_in_range = i_ram_test_select || (32'(ptr_q) < NORMAL_WORDS);
  wire        win_we       = wr_win && win_in_range;
  wire [31:0] win_rdata;   // byte 0 of the table sits in bits 31:24

  filter_table_ram #(
    .WIDTH (32),
    .DEPTH (RAM_WORDS),
    .AW    (10)
  ) u_table (
    .i_ref_clk     (i_ref_clk),
    .i_clk_en      (i_clk_en),
    .i_we          (win_we),
    .i_addr        (ptr_q),
    .i_wdata       (i_reg_wdata),
    .o_rdata       (win_rdata),       // plain copy, reading has no side effect
    .i_lookup_addr (i_lookup_addr),
    .o_lookup_data (o_lookup_data)
  );

  // miss counter next value

  // a missed packet in the cycle of a read or write is added on top, never lost
  wire [31:0] miss_base = wr_miss ? miss_merge : (rd_miss ? 32'h0000_0000 : miss_q);
  wire [31:0] miss_next = miss_base + (i_rx_missed ? 32'h0000_0001 : 32'h0000_0000);
  wire        miss_wrap = i_rx_missed && (miss_base == `MISS_WRAP_FROM);

  // read mux; reserved and unmapped offsets read as zero

  wire [31:0] rd_mux =
      hit_data ? {16'h0000, mgmt_data_q} :
      hit_ctl  ? {20'h00000, busy_q, mgmt_ctl_q} :
      hit_ptr  ? {20'h00000, ptr_q, 2'b00} :
      hit_win  ? win_rdata :
      hit_en   ? 32'(enable_q) :
      hit_miss ? miss_q :
                 32'h0000_0000;

  // next-state decisions

  always_comb begin
    // management data: soft reset, phy read result, host write
    mgmt_data_d = mgmt_data_q;
    if (i_soft_rst) begin
      mgmt_data_d = `RST_MGMT_DATA;
    end else if (mgmt_done && !mgmt_ctl_q[`CTL_WRITE_BIT]) begin
      mgmt_data_d = mgmt_rdata;
    end else if (wr_data && !busy_q) begin
      mgmt_data_d = data_merge[15:0];
    end

    // control fields: only while idle
    mgmt_ctl_d = mgmt_ctl_q;
    if (i_soft_rst) begin
      mgmt_ctl_d = `RST_MGMT_CTRL;
    end else if (wr_ctl && !busy_q) begin
      mgmt_ctl_d = ctl_merge[10:0];
    end

    // busy: raised on start, dropped by the engine
    busy_d = busy_q;
    if (i_soft_rst) begin
      busy_d = 1'b0;
    end else if (mgmt_start) begin
      busy_d = 1'b1;
    end else if (mgmt_done) begin
      busy_d = 1'b0;
    end

    // pointer
    ptr_d = ptr_q;
    if (i_soft_rst) begin
      ptr_d = `RST_POINTER;
    end else if (wr_ptr) begin
      ptr_d = ptr_merge[`PTR_HI:`PTR_LO];
    end

    // entry enables keep their value over a soft reset
    enable_d = enable_q;
    if (wr_en) begin
      enable_d = en_merge[ENTRIES-1:0];
    end

    // miss counter keeps its value over a soft reset
    miss_d = miss_next;

    // wrap flag: a set in the clear cycle wins
    wrap_d = wrap_q;
    if (miss_wrap) begin
      wrap_d = 1'b1;
    end else if (i_miss_wrap_flag_clr) begin
      wrap_d = 1'b0;
    end
  end

  // hardware-reset registers

  // management side and pointer
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mgmt_data_q <= `RST_MGMT_DATA;
      mgmt_ctl_q  <= `RST_MGMT_CTRL;
      busy_q      <= 1'b0;
      ptr_q       <= `RST_POINTER;
    end else if (i_clk_en) begin
      mgmt_data_q <= mgmt_data_d;
      mgmt_ctl_q  <= mgmt_ctl_d;
      busy_q      <= busy_d;
      ptr_q       <= ptr_d;
    end
  end

  // enables, counter and wrap flag: hardware reset clears them, soft reset does not
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      enable_q <= ENTRIES'(`RST_ENABLE);
      miss_q   <= `RST_MISS_COUNT;
      wrap_q   <= 1'b0;
    end else if (i_clk_en) begin
      enable_q <= enable_d;
      miss_q   <= miss_d;
      wrap_q   <= wrap_d;
    end
  end

  // read answer registered one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q  <= 32'h0000_0000;
      rvalid_q <= 1'b0;
    end else if (i_clk_en) begin
      rvalid_q <= i_reg_rd;
      if (i_reg_rd) begin
        rdata_q <= rd_mux;                              // counter value before clear
      end
    end
  end

  // outputs

  assign o_reg_rdata              = rdata_q;
  assign o_reg_rvalid             = rvalid_q;
  assign o_filter_entry_enable    = enable_q;           // cleared entry drops out of filtering
  assign o_miss_counter_wrap_flag = wrap_q;
  assign o_miss_wrap_irq          = wrap_q && i_miss_wrap_irq_enable;

endmodule // mac_phy_mgmt_and_filter_access
`default_nettype wire

// file: mac_mgmt_consts.svh
// register offsets, field positions, reset values and timing for the management/filter block
`ifndef MAC_MGMT_CONSTS_SVH
`define MAC_MGMT_CONSTS_SVH

// register byte offsets on the host register port
`define OFS_PHY_MGMT_DATA     8'h50
`define OFS_PHY_MGMT_CTRL     8'h54
`define OFS_FILTER_POINTER    8'h60
`define OFS_FILTER_WINDOW     8'h64
`define OFS_FILTER_ENABLE     8'h68
`define OFS_MISS_COUNT        8'h6c
`define OFS_RSVD_LO           8'h74
`define OFS_RSVD_HI           8'h78

// management control field positions
`define CTL_BUSY_BIT          11
`define CTL_WRITE_BIT         10
`define CTL_PHY_HI            9
`define CTL_PHY_LO            5
`define CTL_REG_HI            4
`define CTL_REG_LO            0

// filter pointer word address field
`define PTR_HI                11
`define PTR_LO                2

// reset values
`define RST_MGMT_DATA         16'h0000
`define RST_MGMT_CTRL         11'h000
`define RST_POINTER           10'h000
`define RST_ENABLE            21'h00_0000
`define RST_MISS_COUNT        32'h0000_0000

// miss counter wrap point
`define MISS_WRAP_FROM        32'h0000_7fff

// management frame fields
`define MDIO_PREAMBLE         32'hffff_ffff
`define MDIO_START            2'h1
`define MDIO_OP_WRITE         2'h1
`define MDIO_OP_READ          2'h2
`define MDIO_TA_WRITE         2'h2
`define MDIO_FRAME_BITS       7'd64
`define MDIO_READ_RELEASE     7'd46
`define MDIO_READ_DATA_FIRST  7'd48

// timing: reference clock period and least management clock half period
`define REF_CLK_PERIOD_NS     4
`define MDC_HALF_NS           200
`define MDC_HALF_CYCLES       ((`MDC_HALF_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// file: mac_mgmt_pkg.sv
// types shared by the management and filter access block
`default_nettype none
package mac_mgmt_pkg;
  // management frame engine states, one-hot
  typedef enum logic [2:0] {
    MDIO_IDLE = 3'b001,
    MDIO_RUN  = 3'b010,
    MDIO_END  = 3'b100
  } mdio_state_t;
endpackage
`default_nettype wire

// file: filter_table_ram.sv
// word-wide table memory for the address filter and the dma test area
`default_nettype none
module filter_table_ram #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024,
  parameter int AW    = 10
) (
  // clock
  input  wire logic             i_ref_clk,
  input  wire logic             i_clk_en,
  // host side
  input  wire logic             i_we,
  input  wire logic [AW-1:0]    i_addr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_rdata,
  // filter lookup side
  input  wire logic [AW-1:0]    i_lookup_addr,
  output logic      [WIDTH-1:0] o_lookup_data
);
  initial begin
    if (DEPTH < 1 || DEPTH > (1 << AW)) $error("filter_table_ram: depth does not fit address width");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // table words, byte 0 in the top lane
  logic [WIDTH-1:0] lookup_q;     // registered lookup word

  // host read is combinational; the caller registers it
  assign o_rdata       = (32'(i_addr) < DEPTH) ? mem[i_addr] : '0;
  assign o_lookup_data = lookup_q;

  // no reset on the array: contents are undefined until written
  always_ff @(posedge i_ref_clk) begin
    if (i_clk_en) begin
      if (i_we && (32'(i_addr) < DEPTH)) begin
        mem[i_addr] <= i_wdata;
      end
      lookup_q <= (32'(i_lookup_addr) < DEPTH) ? mem[i_lookup_addr] : '0;
    end
  end
endmodule // filter_table_ram
`default_nettype wire

// file: mdio_frame_engine.sv
// serial management frame engine: one read or write frame per start
`include "mac_mgmt_consts.svh"
`default_nettype none
module mdio_frame_engine #(
  parameter int MDC_HALF = `MDC_HALF_CYCLES
) (
  // clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic        i_abort,
  // request
  input  wire logic        i_start,
  input  wire logic        i_write,
  input  wire logic [4:0]  i_phy,
  input  wire logic [4:0]  i_reg,
  input  wire logic [15:0] i_wdata,
  // completion
  output logic             o_done,
  output logic [15:0]      o_rdata,
  // pins
  output logic             o_mdc,
  input  wire logic        i_mdio_in,
  output logic             o_mdio_out,
  output logic             o_mdio_oe
);
  initial begin
    if (MDC_HALF < 1 || MDC_HALF > 255) $error("mdio_frame_engine: half period out of range");
  end

  mac_mgmt_pkg::mdio_state_t state_q;  // frame state
  logic [7:0]  cnt_q;                  // half period counter
  logic [6:0]  idx_q;                  // bit being driven
  logic [63:0] sh_q;                   // outgoing frame
  logic        rd_q;                   // frame is a read
  logic [6:0]  idx_nx;                 // next bit index
  logic [63:0] frame;                  // assembled frame

  assign idx_nx = idx_q + 7'd1;
  assign frame  = {`MDIO_PREAMBLE, `MDIO_START, i_write ? `MDIO_OP_WRITE : `MDIO_OP_READ,
                   i_phy, i_reg, i_write ? `MDIO_TA_WRITE : 2'h0, i_write ? i_wdata : 16'h0000};

  // frame sequencing: drive on falling mdc, sample on rising mdc
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= mac_mgmt_pkg::MDIO_IDLE;
      cnt_q <= 8'h00;
      idx_q <= 7'h00;
      sh_q <= 64'h0;
      rd_q <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 16'h0000;
      o_mdc <= 1'b0;
      o_mdio_out <= 1'b1;
      o_mdio_oe <= 1'b0;
    end else if (i_clk_en) begin
      o_done <= 1'b0;
      if (i_abort) begin
        // soft reset drops the frame and releases the pin
        state_q <= mac_mgmt_pkg::MDIO_IDLE;
        o_mdc <= 1'b0;
        o_mdio_oe <= 1'b0;
      end else begin
        case (state_q)
          mac_mgmt_pkg::MDIO_IDLE: begin
            if (i_start) begin
              sh_q <= frame;
              idx_q <= 7'h00;
              cnt_q <= 8'h00;
              rd_q <= ~i_write;
              o_mdio_out <= frame[63];
              o_mdio_oe <= 1'b1;
              state_q <= mac_mgmt_pkg::MDIO_RUN;
            end
          end
          mac_mgmt_pkg::MDIO_RUN: begin
            if (cnt_q == 8'(MDC_HALF - 1)) begin
              cnt_q <= 8'h00;
              o_mdc <= ~o_mdc;
              if (o_mdc) begin
                // falling edge: move to next bit or finish
                if (idx_nx == `MDIO_FRAME_BITS) begin
                  state_q <= mac_mgmt_pkg::MDIO_END;
                end else begin
                  idx_q <= idx_nx;
                  sh_q <= {sh_q[62:0], 1'b0};
                  o_mdio_out <= sh_q[62];
                  o_mdio_oe <= ~rd_q || (idx_nx < `MDIO_READ_RELEASE);  // phy owns turnaround and data
                end
              end else if (rd_q && idx_q >= `MDIO_READ_DATA_FIRST) begin
                o_rdata <= {o_rdata[14:0], i_mdio_in};  // msb first
              end
            end else begin
              cnt_q <= cnt_q + 8'h01;
            end
          end
          mac_mgmt_pkg::MDIO_END: begin
            o_mdc <= 1'b0;
            o_mdio_oe <= 1'b0;
            o_done <= 1'b1;
            state_q <= mac_mgmt_pkg::MDIO_IDLE;
          end
          default: state_q <= mac_mgmt_pkg::MDIO_IDLE;
        endcase
      end
    end
  end
endmodule // mdio_frame_engine
`default_nettype wire

// file: mgmt_access_checker_assertions.sv
// port-level assertions for the management and filter access block
`default_nettype none
module mgmt_access_checker #(
  parameter int ENTRIES = 21  // entry enable width
) (
  // clock, resets and host port
  input wire logic               i_ref_clk, i_rst_n, i_clk_en, i_soft_rst,
  input wire logic               i_reg_wr, i_reg_rd,
  input wire logic [7:0]         i_reg_addr,
  input wire logic [31:0]        i_reg_wdata, o_reg_rdata,
  input wire logic [3:0]         i_reg_be,
  input wire logic               o_reg_rvalid,
  // wrap flag, entry enables, management pins
  input wire logic               i_miss_wrap_irq_enable, i_miss_wrap_flag_clr,
  input wire logic               o_miss_counter_wrap_flag, o_miss_wrap_irq,
  input wire logic [ENTRIES-1:0] o_filter_entry_enable,
  input wire logic               o_mdc, o_mdio_out, o_mdio_oe
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  // a read taken by the block, frozen cycles excluded
  wire take_rd = i_reg_rd && i_clk_en;
  wire take_en = i_reg_wr && i_clk_en && !i_soft_rst && i_reg_addr == 8'h68 && i_reg_be == 4'hf;

  read_answer_a: assert property (take_rd |=> o_reg_rvalid)
    else $error("read got no answer");
  answer_cause_a: assert property (o_reg_rvalid |-> $past(take_rd))
    else $error("answer without a read");
  hole_zero_a: assert property (take_rd && i_reg_addr inside {8'h74, 8'h78} |=> o_reg_rdata == '0)
    else $error("reserved offset read nonzero");
  enable_write_a: assert property (take_en |=> o_filter_entry_enable == $past(i_reg_wdata[ENTRIES-1:0]))
    else $error("entry enables not written");
  enable_keep_a: assert property (i_soft_rst && i_clk_en && !i_reg_wr |=> $stable(o_filter_entry_enable))
    else $error("soft reset changed enables");
  wrap_irq_gate_a: assert property (o_miss_wrap_irq == (o_miss_counter_wrap_flag && i_miss_wrap_irq_enable))
    else $error("wrap irq not flag and enable");
  wrap_flag_hold_a: assert property (o_miss_counter_wrap_flag && !i_miss_wrap_flag_clr |=> o_miss_counter_wrap_flag)
    else $error("wrap flag dropped by itself");
  frame_preamble_a: assert property ($rose(o_mdio_oe) |-> o_mdio_out)
    else $error("frame does not open with a one");
  mdc_half_a: assert property ($changed(o_mdc) && !i_soft_rst |=> $stable(o_mdc))
    else $error("management clock half period too short");
  soft_abort_a: assert property (i_soft_rst && i_clk_en |=> !o_mdio_oe && !o_mdc)
    else $error("soft reset left a frame running");

  // main scenarios reached
  cover property (take_rd);
  cover property ($rose(o_miss_counter_wrap_flag));
  cover property ($rose(o_mdio_oe));
endmodule // mgmt_access_checker

bind mac_phy_mgmt_and_filter_access mgmt_access_checker #(.ENTRIES(ENTRIES)) i_chk (
  .i_ref_clk, .i_rst_n, .i_clk_en, .i_soft_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
  .o_reg_rdata, .i_reg_be, .o_reg_rvalid, .i_miss_wrap_irq_enable, .i_miss_wrap_flag_clr,
  .o_miss_counter_wrap_flag, .o_miss_wrap_irq, .o_filter_entry_enable, .o_mdc, .o_mdio_out, .o_mdio_oe
);
`default_nettype wire

// file: phy_mgmt_model.sv
// behavioural phy answering management frames
`default_nettype none
module phy_mgmt_model #(
  parameter logic [15:0] RD_WORD = 16'ha5c3  // word returned on reads
) (
  input  wire logic        i_mdc,    // management clock
  input  wire logic        i_mdio,   // resolved wire level
  input  wire logic        i_start,  // controller enable, rises at frame start
  output var bit           o_oe,     // phy drives the wire
  output var bit           o_out,
  output logic [63:0]      o_frame,  // last 64 bits seen
  output int               o_cnt     // rising edges in this frame
);
  timeunit 1ns;
  timeprecision 1ps;
  bit rd_op;  // current frame is a read
  // sample on each rising edge; enable rising with mdc low restarts the count
  always @(posedge i_mdc or posedge i_start) begin
    if (i_mdc) begin
      o_frame <= {o_frame[62:0], i_mdio};
      o_cnt   <= o_cnt + 1;
    end else begin
      o_cnt <= 0;
    end
  end
  // after falling edges: turnaround zero on bit 47, then the word msb first
  always @(negedge i_mdc) begin
    if (o_cnt == 36) rd_op <= (o_frame[1:0] == 2'b10);
    o_oe  <= rd_op && o_cnt >= 47 && o_cnt < 64;
    o_out <= (o_cnt == 47) ? 1'b0 : RD_WORD[63 - o_cnt];
  end
endmodule // phy_mgmt_model
`default_nettype wire

// file: test_mac_phy_mgmt_and_filter_access.sv
// self-checking bench for the management and filter access block
`default_nettype none
module test_mac_phy_mgmt_and_filter_access;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] RD_WORD = 16'ha5c3;  // phy read answer
  logic        i_ref_clk, i_rst_n, i_clk_en, i_soft_rst, i_reg_wr, i_reg_rd, o_reg_rvalid;
  logic [7:0]  i_reg_addr;
  logic [31:0] i_reg_wdata, o_reg_rdata, o_lookup_data, e, a;
  logic [3:0]  i_reg_be;
  logic        i_rx_missed, i_ram_test_select, i_miss_wrap_irq_enable, i_miss_wrap_flag_clr;
  logic        o_miss_counter_wrap_flag, o_miss_wrap_irq, o_mdc, o_mdio_out, o_mdio_oe, phy_oe, phy_out;
  logic [20:0] o_filter_entry_enable;
  logic [9:0]  i_lookup_addr;
  logic [63:0] frame, exp_q[$];  // expected read words, oldest first
  logic [10:0] c;
  wire         i_mdio_in;
  int          cnt, num_errors, n_compared, n, seed;
  logic [7:0]  ofs[7] = '{8'h50, 8'h54, 8'h60, 8'h68, 8'h6c, 8'h74, 8'h78};
  // pull-up holds a released line high
  assign i_mdio_in = o_mdio_oe ? o_mdio_out : (phy_oe ? phy_out : 1'b1);

  mac_phy_mgmt_and_filter_access #(.MDC_HALF(2)) i_dut (
    .i_ref_clk, .i_rst_n, .i_clk_en, .i_soft_rst, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
    .i_reg_be, .o_reg_rdata, .o_reg_rvalid, .i_rx_missed, .i_ram_test_select, .i_miss_wrap_irq_enable,
    .i_miss_wrap_flag_clr, .o_miss_counter_wrap_flag, .o_miss_wrap_irq, .o_filter_entry_enable,
    .i_lookup_addr, .o_lookup_data, .o_mdc, .i_mdio_in, .o_mdio_out, .o_mdio_oe);
  phy_mgmt_model #(.RD_WORD(RD_WORD)) i_phy (.i_mdc(o_mdc), .i_mdio(i_mdio_in), .i_start(o_mdio_oe),
    .o_oe(phy_oe), .o_out(phy_out), .o_frame(frame), .o_cnt(cnt));

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one register port cycle; strobes stand for exactly one edge
  task automatic acc(input logic w, r, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] be);
    i_reg_wr    <= w;
    i_reg_rd    <= r;
    i_reg_addr  <= ad;
    i_reg_wdata <= d;
    i_reg_be    <= be;
    @(posedge i_ref_clk);
  endtask
  task automatic idle(input int k);
    repeat (k) acc(1'b0, 1'b0, 8'h0, 32'h0, 4'h0);
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    acc(1'b1, 1'b0, ad, d, 4'hf);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [63:0] x);
    exp_q.push_back(x);
    acc(1'b0, 1'b1, ad, 32'h0, 4'hf);
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // clock at 4 ns
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // answered reads against the oldest note
  always @(posedge i_ref_clk)
    if (o_reg_rvalid === 1'b1) chk("rdata", o_reg_rdata, exp_q.pop_front());
  // hang guard, far beyond the expected run
  initial begin
    #40000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {i_rst_n, i_soft_rst, i_reg_wr, i_reg_rd, i_rx_missed, i_ram_test_select} = '0;
    {i_miss_wrap_irq_enable, i_miss_wrap_flag_clr, i_reg_addr, i_reg_wdata, i_reg_be, i_lookup_addr} = '0;
    i_clk_en = 1'b1;
    seed = 65;
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    // reset values, reserved holes written first
    wr(8'h74, '1);
    wr(8'h78, '1);
    foreach (ofs[i]) rd(ofs[i], 64'h0);
    $display("reset values done");
    // test area word refused in normal mode, then pointer and window
    i_ram_test_select <= 1'b1;
    wr(8'h60, 32'h100);
    a = $random(seed);
    acc(1'b1, 1'b0, 8'h64, a, 4'h0);
    i_ram_test_select <= 1'b0;
    wr(8'h64, ~a);
    rd(8'h64, a);
    wr(8'h60, 32'hffff_f017);
    rd(8'h60, 32'h14);
    e = $random(seed);
    acc(1'b1, 1'b0, 8'h64, e, 4'h0);
    rd(8'h64, e);
    rd(8'h64, e);
    i_lookup_addr <= 10'h5;
    idle(2);
    chk("lookup", o_lookup_data, e);
    $display("filter table done");
    // soft reset keeps enables and counter, clears data and pointer
    wr(8'h6c, 32'h7ffe);
    wr(8'h68, e);
    wr(8'h50, e);
    rd(8'h50, e[15:0]);
    i_soft_rst <= 1'b1;
    idle(1);
    i_soft_rst <= 1'b0;
    rd(8'h68, e[20:0]);
    rd(8'h50, 0);
    rd(8'h60, 0);
    i_miss_wrap_irq_enable <= 1'b1;
    i_rx_missed <= 1'b1;
    idle(2);
    i_rx_missed <= 1'b0;
    rd(8'h6c, 32'h8000);
    chk("wrap flag", o_miss_counter_wrap_flag, 1);
    chk("wrap irq", o_miss_wrap_irq, 1);
    i_miss_wrap_flag_clr <= 1'b1;
    n = 1 + ($random(seed) & 7);
    i_rx_missed <= 1'b1;
    idle(n);
    {i_rx_missed, i_miss_wrap_flag_clr} <= 2'b00;
    rd(8'h6c, n);
    rd(8'h6c, 0);
    chk("wrap flag", o_miss_counter_wrap_flag, 0);
    $display("counter done");
    // one write frame, then one read frame
    for (int w = 1; w >= 0; w--) begin
      e = $random(seed);
      c = {w[0], e[20:16], e[25:21]};
      wr(8'h50, e[15:0]);
      wr(8'h54, {20'h0, 1'b1, c});
      rd(8'h54, {20'h0, 1'b1, c});
      for (int t = 0; t < 600 && cnt < 64; t++) idle(1);
      idle(8);
      i_clk_en <= 1'b0;
      wr(8'h60, '1);
      i_clk_en <= 1'b1;
      rd(8'h60, 0);
      rd(8'h54, {20'h0, 1'b0, c});
      rd(8'h50, w ? e[15:0] : RD_WORD);
      chk("frame", frame, {32'hffff_ffff, 2'b01, w ? 2'b01 : 2'b10, c[9:0], 2'b10, w ? e[15:0] : RD_WORD});
    end
    idle(2);
    chk("pending", exp_q.size(), 0);
    $display("management frames done");
    tally_and_finish();
  end
endmodule // test_mac_phy_mgmt_and_filter_access
`default_nettype wire
